// File: hw/pwmasd_map.svh
// register offsets, field positions, reset values and timing counts of the pwm output stage
`ifndef PWMASD_MAP_SVH
`define PWMASD_MAP_SVH

// ****************************************************************
// register offsets (8-bit address space)
// ****************************************************************
`define PWMASD_OFF_SHUTDOWN  8'h00
`define PWMASD_OFF_DEADBAND  8'h01
`define PWMASD_OFF_CONTROL   8'h02
`define PWMASD_OFF_IRQ_STAT  8'h03
`define PWMASD_OFF_IRQ_MASK  8'h04

// ****************************************************************
// shutdown control register fields
// ****************************************************************
`define PWMASD_SD_STAT_BIT   7
`define PWMASD_SD_SRC_HI     6
`define PWMASD_SD_SRC_LO     4
`define PWMASD_SD_AC_HI      3
`define PWMASD_SD_AC_LO      2
`define PWMASD_SD_BD_HI      1
`define PWMASD_SD_BD_LO      0

// source select bits inside the three-bit field
`define PWMASD_SRC_EXT_INT   0
`define PWMASD_SRC_COMP_ONE  1
`define PWMASD_SRC_COMP_TWO  2

// pair shutdown state codes
`define PWMASD_PSS_DRIVE0    2'h0
`define PWMASD_PSS_DRIVE1    2'h1
`define PWMASD_PSS_TRI_BIT   1

// ****************************************************************
// dead-band and control register fields
// ****************************************************************
`define PWMASD_DB_HI         6
`define PWMASD_DB_LO         0
`define PWMASD_CTL_STEER_HI  1
`define PWMASD_CTL_STEER_LO  0
`define PWMASD_CTL_EN_BIT    2

// interrupt status / mask bits
`define PWMASD_IRQ_SHUTDOWN  0
`define PWMASD_IRQ_STARTED   1

// ****************************************************************
// reset values
// ****************************************************************
`define PWMASD_RST_SHUTDOWN  8'h00
`define PWMASD_RST_DEADBAND  7'h00
`define PWMASD_RST_CONTROL   3'h0
`define PWMASD_RST_IRQ       2'h0

// ****************************************************************
// timing: one instruction cycle is four oscillator (clk_sys) periods
// ****************************************************************
`define PWMASD_CLK_PERIOD_NS 5
`define PWMASD_TCY_OSC       4

`endif

// File: hw/pwmasd_pkg.sv
// types shared by the pwm auto-shutdown and dead-band output stage
package pwmasd_pkg;

  // output steering modes
  typedef enum logic [1:0] {
    PWMASD_MODE_SINGLE   = 2'h0,
    PWMASD_MODE_FULL_FWD = 2'h1,
    PWMASD_MODE_HALF     = 2'h2,
    PWMASD_MODE_FULL_REV = 2'h3
  } pwmasd_mode_type;

  // output start sequencer, one-hot
  typedef enum logic [2:0] {
    PWMASD_ST_IDLE = 3'h1,
    PWMASD_ST_WAIT = 3'h2,
    PWMASD_ST_RUN  = 3'h4
  } pwmasd_state_type;

  // level and enable of the four pins, index 0..3 = a, b, c, d
  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] oe;
  } pwmasd_pins_type;

  // shutdown control register image
  typedef struct packed {
    logic       status;
    logic [2:0] src_sel;
    logic [1:0] pss_ac;
    logic [1:0] pss_bd;
  } pwmasd_sdctl_type;

endpackage : pwmasd_pkg

// File: hw/pwmasd_deadband.sv
// rising-edge delay cell: passes falls at once and delays rises by a cycle count
`timescale 1ns/1ps

module pwmasd_deadband (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       level_i,
  input  wire logic       bypass_i,
  input  wire logic [8:0] delay_i,
  output logic            level_o
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       lvl_q;
  logic       lvl_d;
  logic       expired;

  // count while the wanted level is active; a fall clears at once
  assign expired = bypass_i | (cnt_q >= delay_i);
  assign lvl_d   = level_i & expired;
  assign cnt_d   = (!level_i) ? 9'h000 : (expired ? cnt_q : 9'(cnt_q + 9'h001));

  // ****************************************************************
  // delay state
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 9'h000;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

endmodule : pwmasd_deadband

// File: hw/pwmasd_top.sv
// pwm output stage: steering, start hold-off, dead-band and auto-shutdown
`timescale 1ns/1ps
`include "pwmasd_map.svh"

// ****************************************************************
// pwmasd_top
// ****************************************************************
module pwmasd_top
  import pwmasd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // modulated signal and period marker from the rest of the unit
  input  wire logic       pwm_mod_i,
  input  wire logic       period_start_i,
  // shutdown sources
  input  wire logic       ext_int_n_i,
  input  wire logic       comparator_one_i,
  input  wire logic       comparator_two_i,
  // output pins toward the bridge drivers, and the interrupt request
  output logic            pwm_out_a_o,
  output logic            pwm_out_a_oe_o,
  output logic            pwm_out_b_o,
  output logic            pwm_out_b_oe_o,
  output logic            pwm_out_c_o,
  output logic            pwm_out_c_oe_o,
  output logic            pwm_out_d_o,
  output logic            pwm_out_d_oe_o,
  output logic            irq_o
);

  import pwmasd_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  pwmasd_sdctl_type sdctl_q;
  logic             sd_status_d;
  logic       [6:0] db_len_q;
  pwmasd_mode_type  steer_q;
  logic             pwm_en_q;
  logic       [1:0] irq_stat_q;
  logic       [1:0] irq_stat_d;
  logic       [1:0] irq_mask_q;
  logic             irq_q;
  logic       [7:0] rdata_q;
  logic       [7:0] rdata_d;
  pwmasd_state_type state_q;
  pwmasd_state_type state_d;
  pwmasd_pins_type  pins_q;
  pwmasd_pins_type  pins_d;
  pwmasd_pins_type  pins_safe;

  logic             wr_sd;
  logic             wr_db;
  logic             wr_ctl;
  logic             wr_ist;
  logic             wr_imk;
  logic       [2:0] hw_src;
  logic             hw_evt;
  logic             sw_set;
  logic             sw_clr;
  logic             sd_set_evt;
  logic             shut_now;
  logic             run;
  logic             start_evt;
  logic             is_half;
  logic       [8:0] db_cycles;
  logic       [3:0] raw_lvl;
  logic       [3:0] raw_oe;
  logic             db_a;
  logic             db_b;
  logic             ac_lvl;
  logic             ac_oe;
  logic             bd_lvl;
  logic             bd_oe;

  // ****************************************************************
  // register write decode
  // ****************************************************************
  // one strobe per register; unmapped writes fall through harmlessly
  assign wr_sd  = wr_i & (addr_i == `PWMASD_OFF_SHUTDOWN);
  assign wr_db  = wr_i & (addr_i == `PWMASD_OFF_DEADBAND);
  assign wr_ctl = wr_i & (addr_i == `PWMASD_OFF_CONTROL);
  assign wr_ist = wr_i & (addr_i == `PWMASD_OFF_IRQ_STAT);
  assign wr_imk = wr_i & (addr_i == `PWMASD_OFF_IRQ_MASK);

  // ****************************************************************
  // shutdown sources and status
  // ****************************************************************
  // armed hardware sources; the external pin trips on a low level
  assign hw_src[`PWMASD_SRC_EXT_INT]  = ~ext_int_n_i;
  assign hw_src[`PWMASD_SRC_COMP_ONE] = comparator_one_i;
  assign hw_src[`PWMASD_SRC_COMP_TWO] = comparator_two_i;
  assign hw_evt = |(hw_src & sdctl_q.src_sel);

  // a software write of one counts as an event just like a source
  assign sw_set = wr_sd & wdata_i[`PWMASD_SD_STAT_BIT];
  assign sw_clr = wr_sd & ~wdata_i[`PWMASD_SD_STAT_BIT];

  // set beats clear: an event arriving with a clear write is kept,
  // so a source still active makes the clear ineffective
  assign sd_status_d = (hw_evt | sw_set) ? 1'b1 :
                       (sw_clr ? 1'b0 : sdctl_q.status);

  assign sd_set_evt = (hw_evt | sw_set) & ~sdctl_q.status;

  // combinational path from sources to pins: no clock edge is needed,
  // the stored status then holds the pins once the source is gone;
  // a source pulse shorter than a clock still forces the pins, but the
  // status only latches if the source is active at a rising edge
  assign shut_now = hw_evt | sdctl_q.status;

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdctl_q  <= pwmasd_sdctl_type'(`PWMASD_RST_SHUTDOWN);
      db_len_q <= `PWMASD_RST_DEADBAND;
      steer_q  <= PWMASD_MODE_SINGLE;
      pwm_en_q <= 1'b0;
    end else begin
      sdctl_q.status <= sd_status_d;
      if (wr_sd) begin
        sdctl_q.src_sel <= wdata_i[`PWMASD_SD_SRC_HI:`PWMASD_SD_SRC_LO];
        sdctl_q.pss_ac  <= wdata_i[`PWMASD_SD_AC_HI:`PWMASD_SD_AC_LO];
        sdctl_q.pss_bd  <= wdata_i[`PWMASD_SD_BD_HI:`PWMASD_SD_BD_LO];
      end
      if (wr_db) begin
        db_len_q <= wdata_i[`PWMASD_DB_HI:`PWMASD_DB_LO];
      end
      if (wr_ctl) begin
        steer_q  <= pwmasd_mode_type'(wdata_i[`PWMASD_CTL_STEER_HI:`PWMASD_CTL_STEER_LO]);
        pwm_en_q <= wdata_i[`PWMASD_CTL_EN_BIT];
      end
    end
  end

  // ****************************************************************
  // start sequencer
  // ****************************************************************
  // after enable, wait for a period boundary so the first pulse is whole
  // dropping enable goes back to idle, so a re-enable waits for a fresh period
  always_comb begin
    state_d = state_q;
    case (state_q)
      PWMASD_ST_IDLE: begin
        if (pwm_en_q) begin
          state_d = PWMASD_ST_WAIT;
        end
      end
      PWMASD_ST_WAIT: begin
        if (!pwm_en_q) begin
          state_d = PWMASD_ST_IDLE;
        end else if (period_start_i) begin
          state_d = PWMASD_ST_RUN;
        end
      end
      PWMASD_ST_RUN: begin
        if (!pwm_en_q) begin
          state_d = PWMASD_ST_IDLE;
        end
      end
      default: begin
        state_d = PWMASD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= PWMASD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign run       = (state_q == PWMASD_ST_RUN);
  assign start_evt = (state_q == PWMASD_ST_WAIT) & pwm_en_q & period_start_i;

  // ****************************************************************
  // output steering
  // ****************************************************************
  // pins idle low and undriven until the sequencer reaches run
  // a mode change while running is not aligned to the period boundary
  assign is_half = (steer_q == PWMASD_MODE_HALF);

  // pin a: modulated in single and half, active in forward
  assign raw_lvl[0] = run & ((steer_q == PWMASD_MODE_SINGLE) ? pwm_mod_i :
                             is_half ? pwm_mod_i :
                             (steer_q == PWMASD_MODE_FULL_FWD));
  // pin b: complement in half, modulated in reverse
  assign raw_lvl[1] = run & (is_half ? ~pwm_mod_i :
                             (steer_q == PWMASD_MODE_FULL_REV) & pwm_mod_i);
  // pin c: active only in reverse
  assign raw_lvl[2] = run & (steer_q == PWMASD_MODE_FULL_REV);
  // pin d: modulated only in forward
  assign raw_lvl[3] = run & (steer_q == PWMASD_MODE_FULL_FWD) & pwm_mod_i;

  // which pins the mode owns; others stay released for general i/o
  assign raw_oe[0] = run;
  assign raw_oe[1] = run & (steer_q != PWMASD_MODE_SINGLE);
  assign raw_oe[2] = run & steer_q[0];
  assign raw_oe[3] = run & steer_q[0];

  // ****************************************************************
  // dead-band
  // ****************************************************************
  // seven-bit length in instruction cycles, each four clocks long
  // longest band is 127 x 4 = 508 clocks, inside the nine-bit counter
  assign db_cycles = 9'({2'h0, db_len_q} * `PWMASD_TCY_OSC);

  // only rises are delayed; outside half-bridge the cells pass straight
  // a and b count separately, so each edge of the pair gets its own band
  pwmasd_deadband u_db_a (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .level_i   (raw_lvl[0]),
    .bypass_i  (~is_half),
    .delay_i   (db_cycles),
    .level_o   (db_a)
  );

  pwmasd_deadband u_db_b (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .level_i   (raw_lvl[1]),
    .bypass_i  (~is_half),
    .delay_i   (db_cycles),
    .level_o   (db_b)
  );

  // c and d get one flop so all four pins share the same latency
  // a and b take their flop inside the dead-band cells instead
  assign pins_d.lvl = {raw_lvl[3], raw_lvl[2], 2'h0};
  assign pins_d.oe  = raw_oe;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  // ****************************************************************
  // shutdown pin states
  // ****************************************************************
  // each pair decodes its own field: drive 0, drive 1 or release
  // code 00 drives low, 01 drives high, 1x releases the pair
  assign ac_lvl = (sdctl_q.pss_ac == `PWMASD_PSS_DRIVE1);
  assign ac_oe  = ~sdctl_q.pss_ac[`PWMASD_PSS_TRI_BIT];
  assign bd_lvl = (sdctl_q.pss_bd == `PWMASD_PSS_DRIVE1);
  assign bd_oe  = ~sdctl_q.pss_bd[`PWMASD_PSS_TRI_BIT];

  // only pins the mode has enabled are forced; released pins stay released
  assign pins_safe.lvl = {bd_lvl, ac_lvl, bd_lvl, ac_lvl};
  assign pins_safe.oe  = pins_q.oe & {bd_oe, ac_oe, bd_oe, ac_oe};

  // pins leave the flops except under shutdown, which must not wait
  // for a clock edge; this is the one combinational path to the pins
  assign pwm_out_a_o    = shut_now ? pins_safe.lvl[0] : db_a;
  assign pwm_out_b_o    = shut_now ? pins_safe.lvl[1] : db_b;
  assign pwm_out_c_o    = shut_now ? pins_safe.lvl[2] : pins_q.lvl[2];
  assign pwm_out_d_o    = shut_now ? pins_safe.lvl[3] : pins_q.lvl[3];
  assign pwm_out_a_oe_o = shut_now ? pins_safe.oe[0] : pins_q.oe[0];
  assign pwm_out_b_oe_o = shut_now ? pins_safe.oe[1] : pins_q.oe[1];
  assign pwm_out_c_oe_o = shut_now ? pins_safe.oe[2] : pins_q.oe[2];
  assign pwm_out_d_oe_o = shut_now ? pins_safe.oe[3] : pins_q.oe[3];

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // sticky bits, write one to clear; a new event in the clear cycle wins
  assign irq_stat_d[`PWMASD_IRQ_SHUTDOWN] = sd_set_evt |
      (irq_stat_q[`PWMASD_IRQ_SHUTDOWN] & ~(wr_ist & wdata_i[`PWMASD_IRQ_SHUTDOWN]));
  assign irq_stat_d[`PWMASD_IRQ_STARTED] = start_evt |
      (irq_stat_q[`PWMASD_IRQ_STARTED] & ~(wr_ist & wdata_i[`PWMASD_IRQ_STARTED]));

  // the mask meets the next status, so irq_o rises with the flag, not a cycle later
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_q <= `PWMASD_RST_IRQ;
      irq_mask_q <= `PWMASD_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_imk) begin
        irq_mask_q <= wdata_i[1:0];
      end
      irq_q <= |(irq_stat_d & (wr_imk ? wdata_i[1:0] : irq_mask_q));
    end
  end

  assign irq_o = irq_q;

  // ****************************************************************
  // read back
  // ****************************************************************
  // data valid only in the cycle after the read strobe, zero otherwise
  // reads have no side effects, so polling the status never loses a flag
  always_comb begin
    rdata_d = 8'h00;
    case (addr_i)
      `PWMASD_OFF_SHUTDOWN: rdata_d = sdctl_q;
      `PWMASD_OFF_DEADBAND: rdata_d = {1'b0, db_len_q};
      `PWMASD_OFF_CONTROL:  rdata_d = {5'h00, pwm_en_q, steer_q};
      `PWMASD_OFF_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
      `PWMASD_OFF_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
      default:              rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rdata_d : 8'h00;
    end
  end

  assign rdata_o = rdata_q;

endmodule : pwmasd_top

// File: tb/pwmasd_bridge.sv
// bridge gate-driver model that sits on the four pwm pins
`timescale 1ns/1ps

// ****************************************************************
// pwmasd_bridge
// ****************************************************************
module pwmasd_bridge
  import pwmasd_pkg::*;
(
  input  wire pwmasd_pkg::pwmasd_pins_type pins_i,
  output logic [3:0]                       gate_o,
  output logic                             shoot_o
);
  import pwmasd_pkg::*;
  // a released pin is held off by the driver's pull-down, so it never floats on
  assign gate_o = pins_i.lvl & pins_i.oe;
  // upper (a) and lower (b) switch of one leg on together would short the supply
  assign shoot_o = gate_o[0] & gate_o[1];
endmodule : pwmasd_bridge

// File: tb/pwmasd_assertions.sv
// port-level concurrent checks of the pwm output stage
`timescale 1ns/1ps
`include "pwmasd_map.svh"

// ****************************************************************
// pwmasd_chk
// ****************************************************************
module pwmasd_chk
  import pwmasd_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       pwm_mod_i,
  input wire logic       period_start_i,
  input wire logic       ext_int_n_i,
  input wire logic       comparator_one_i,
  input wire logic       comparator_two_i,
  input wire logic       pwm_out_a_o,
  input wire logic       pwm_out_a_oe_o,
  input wire logic       pwm_out_b_o,
  input wire logic       pwm_out_b_oe_o,
  input wire logic       pwm_out_c_o,
  input wire logic       pwm_out_c_oe_o,
  input wire logic       pwm_out_d_o,
  input wire logic       pwm_out_d_oe_o,
  input wire logic       irq_o
);
  import pwmasd_pkg::*;
  logic [2:0] src_q;
  logic [1:0] ac_q, bd_q, mode_q, mask_q;
  logic [6:0] db_q;
  logic       stat_q, en_q, run_q;
  // shadow of software settings from the register port; status and run also follow the source and period inputs
  wire w_sd = wr_i && addr_i == `PWMASD_OFF_SHUTDOWN;
  wire w_ct = wr_i && addr_i == `PWMASD_OFF_CONTROL;
  wire src_act = (src_q[0] & ~ext_int_n_i) | (src_q[1] & comparator_one_i)
               | (src_q[2] & comparator_two_i);
  wire sd = src_act | stat_q;
  wire [7:0] sd_img = {stat_q, src_q, ac_q, bd_q};
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {src_q, ac_q, bd_q, stat_q, mode_q, en_q, run_q, mask_q, db_q} <= '0;
    end else begin
      if (w_sd) {src_q, ac_q, bd_q} <= wdata_i[6:0];
      if (w_ct) {en_q, mode_q} <= wdata_i[2:0];
      if (wr_i && addr_i == `PWMASD_OFF_DEADBAND) db_q <= wdata_i[6:0];
      if (wr_i && addr_i == `PWMASD_OFF_IRQ_MASK) mask_q <= wdata_i[1:0];
      // a set from any source wins over a software clear
      stat_q <= src_act | (w_sd & wdata_i[7]) | (stat_q & ~w_sd);
      run_q <= en_q & (run_q | period_start_i);
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_safe_ac: assert property (sd && !ac_q[1] && pwm_out_a_oe_o |-> pwm_out_a_o == ac_q[0])
    else $error("pair ac safe level wrong");
  a_safe_bd: assert property (sd && !bd_q[1] && pwm_out_b_oe_o |-> pwm_out_b_o == bd_q[0])
    else $error("pair bd safe level wrong");
  a_tri_release: assert property (sd && ac_q[1] |-> !pwm_out_a_oe_o && !pwm_out_c_oe_o)
    else $error("tri-state pair still driven");
  a_status_read: assert property (rd_i && addr_i == `PWMASD_OFF_SHUTDOWN |=> rdata_o == $past(sd_img))
    else $error("shutdown register read wrong");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_irq_masked: assert property (mask_q == 2'h0 [*2] |-> !irq_o)
    else $error("masked interrupt raised");
  a_no_overlap: assert property (!(ac_q == 2'h1 && bd_q == 2'h1) |-> !(pwm_out_a_o && pwm_out_b_o && pwm_out_a_oe_o && pwm_out_b_oe_o))
    else $error("both half-bridge switches on");
  a_rise_delay: assert property (mode_q == PWMASD_MODE_HALF && db_q == 7'h01 && run_q && !sd && $rose(pwm_mod_i) |=> !pwm_out_a_o [*4])
    else $error("rising edge not delayed");
  a_fall_fast: assert property (mode_q == PWMASD_MODE_HALF && run_q && !sd && $fell(pwm_mod_i) |=> !pwm_out_a_o)
    else $error("falling edge delayed");
  a_start_hold: assert property (en_q && !run_q && !sd |-> !pwm_out_a_oe_o && !pwm_out_b_oe_o)
    else $error("output before new period");
  c_shutdown: cover property (sd && pwm_out_a_oe_o);
  c_irq: cover property ($rose(irq_o));
  c_half: cover property (run_q && mode_q == PWMASD_MODE_HALF);
endmodule : pwmasd_chk

bind pwmasd_top pwmasd_chk pwmasd_chk_inst (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .pwm_mod_i, .period_start_i, .ext_int_n_i, .comparator_one_i,
  .comparator_two_i, .pwm_out_a_o, .pwm_out_a_oe_o, .pwm_out_b_o, .pwm_out_b_oe_o,
  .pwm_out_c_o, .pwm_out_c_oe_o, .pwm_out_d_o, .pwm_out_d_oe_o, .irq_o);

// File: tb/pwmasd_top_test.sv
// self-checking bench of the pwm output stage
`timescale 1ns/1ps
`include "pwmasd_map.svh"

// ****************************************************************
// pwmasd_top_test
// ****************************************************************
module pwmasd_top_test;
  import pwmasd_pkg::*;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic pwm_mod_i = 1'b0, period_start_i = 1'b0, ext_int_n_i = 1'b1;
  logic comparator_one_i = 1'b0, comparator_two_i = 1'b0;
  logic pwm_out_a_o, pwm_out_a_oe_o, pwm_out_b_o, pwm_out_b_oe_o;
  logic pwm_out_c_o, pwm_out_c_oe_o, pwm_out_d_o, pwm_out_d_oe_o, irq_o, shoot;
  logic [3:0] gate;
  pwmasd_pins_type pins;
  int n_errors = 0, n_tests = 0, cyc = 0, shoots = 0;
  assign pins.lvl = {pwm_out_d_o, pwm_out_c_o, pwm_out_b_o, pwm_out_a_o};
  assign pins.oe = {pwm_out_d_oe_o, pwm_out_c_oe_o, pwm_out_b_oe_o, pwm_out_a_oe_o};
  pwmasd_top pwmasd_top_inst (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pwm_mod_i, .period_start_i, .ext_int_n_i, .comparator_one_i,
    .comparator_two_i, .pwm_out_a_o, .pwm_out_a_oe_o, .pwm_out_b_o, .pwm_out_b_oe_o,
    .pwm_out_c_o, .pwm_out_c_oe_o, .pwm_out_d_o, .pwm_out_d_oe_o, .irq_o);
  pwmasd_bridge pwmasd_bridge_inst (.pins_i(pins), .gate_o(gate), .shoot_o(shoot));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // cycle ceiling well above the roughly 130 cycles the scenarios need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (shoot === 1'b1) shoots++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // one-cycle strobe, then an idle edge so strobes never collide in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 check(name, exp, rdata_o);
    @(posedge clk_sys_i);
  endtask : rdc
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rdc(8'(i), 8'h00, "reset value");
    wr(8'h07, 8'hff);
    rdc(8'h07, 8'h00, "unmapped");
    wr(`PWMASD_OFF_DEADBAND, 8'hff);
    rdc(`PWMASD_OFF_DEADBAND, 8'h7f, "dead-band length");
  endtask : t_regs
  // half-bridge with one instruction cycle of dead band
  task automatic t_half();
    int n;
    wr(`PWMASD_OFF_DEADBAND, 8'h01);
    wr(`PWMASD_OFF_CONTROL, 8'h06);
    repeat (6) @(posedge clk_sys_i);
    #1 check("oe before period", 8'h00, {4'h0, pins.oe});
    period_start_i <= 1'b1;
    @(posedge clk_sys_i);
    period_start_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #1 check("half oe", 8'h03, {4'h0, pins.oe});
    check("b complement", 8'h01, {7'h0, pwm_out_b_o});
    pwm_mod_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (pwm_out_a_o !== 1'b1 && n < 20);
    check("a rise cycles", 8'(1 + `PWMASD_TCY_OSC * 1), 8'(n));
    pwm_mod_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 check("a fall", 8'h00, {7'h0, pwm_out_a_o});
    check("b rise held", 8'h00, {7'h0, pwm_out_b_o});
    repeat (8) @(posedge clk_sys_i);
    rdc(`PWMASD_OFF_IRQ_STAT, 8'h02, "started flag");
    wr(`PWMASD_OFF_IRQ_STAT, 8'h02);
  endtask : t_half
  // each hardware source in turn, pair a/c drives 1, pair b/d drives 0
  task automatic t_sources();
    logic [7:0] v;
    wr(`PWMASD_OFF_IRQ_MASK, 8'h01);
    for (int k = 0; k < 3; k++) begin
      v = 8'h04 | (8'h10 << k);
      wr(`PWMASD_OFF_SHUTDOWN, v);
      ext_int_n_i <= (k != 0);
      comparator_one_i <= (k == 1);
      comparator_two_i <= (k == 2);
      #1 check("safe pins", 8'h01, {6'h0, pwm_out_b_o, pwm_out_a_o});
      @(posedge clk_sys_i);
      ext_int_n_i <= 1'b1;
      comparator_one_i <= 1'b0;
      comparator_two_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 check("irq raised", 8'h01, {7'h0, irq_o});
      rdc(`PWMASD_OFF_SHUTDOWN, v | 8'h80, "sticky status");
      #1 check("still safe", 8'h01, {7'h0, pwm_out_a_o});
      wr(`PWMASD_OFF_SHUTDOWN, v);
      wr(`PWMASD_OFF_IRQ_STAT, 8'h01);
      @(posedge clk_sys_i);
      #1 check("irq cleared", 8'h00, {7'h0, irq_o});
      check("normal a", 8'h00, {7'h0, pwm_out_a_o});
    end
  endtask : t_sources
  task automatic t_sw_tri();
    wr(`PWMASD_OFF_SHUTDOWN, 8'h8a);
    #1 check("released oe", 8'h00, {4'h0, pins.oe});
    check("gates off", 8'h00, {4'h0, gate});
    rdc(`PWMASD_OFF_SHUTDOWN, 8'h8a, "software status");
    wr(`PWMASD_OFF_SHUTDOWN, 8'h00);
    #1 check("oe resumed", 8'h03, {4'h0, pins.oe});
  endtask : t_sw_tri
  // single, full forward and full reverse, with the modulated signal high
  task automatic t_modes();
    logic [7:0] ctl[3] = '{8'h04, 8'h05, 8'h07};
    logic [7:0] exp[3] = '{8'h11, 8'hf9, 8'hf6};
    pwm_mod_i <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(`PWMASD_OFF_CONTROL, ctl[m]);
      repeat (3) @(posedge clk_sys_i);
      #1 check("mode pins", exp[m], {pins.oe, pins.lvl & pins.oe});
    end
    wr(`PWMASD_OFF_CONTROL, 8'h00);
    @(posedge clk_sys_i);
    #1 check("disabled oe", 8'h00, {4'h0, pins.oe});
  endtask : t_modes
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_half();
    t_sources();
    t_sw_tri();
    t_modes();
    check("shoot-through", 8'h00, 8'(shoots));
    end_sim();
  end
endmodule : pwmasd_top_test
